//--- verilog/dpl_core.sv
`timescale 1ns/1ns
// Overview of operation
// - Link control only when selector equals 8
// - Act on link control, report status
// - Master copies own control word out
// - Control bits 5..8: loop, power, free, stop
// - Control bit 9 homes, bit 10 clears
// - Status bits 5..9 report drive flags
// - Status bits 13..15 hold drive state
// - Mode selection loads preset data maps
// - User mode: maps only stored, link words routed as in slave modes
// - Map write of a changed value forces user mode
// - Speed master sends torque then speed
// - Speed master receives error number, location
// - Slave 1 uses master speed reference
// - Secondary reference is percent of primary
// - Threshold replaces too small secondary
// - Secondary sign follows master torque
// - Slave 1 torque limit tracks master torque
// - Slave 2 injects master torque pre-control
// - Slave 2 speed reference, optional lag filter
// - Slave 2 speed loop proportional only
// - Slave 2 maps equal slave 1 maps
// - Scaled values are signed 16-bit
module dpl_core
  import dpl_pkg::*;
#(
  parameter int PCT_W = 7
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [15:0] own_ctrl_i,
  input wire logic [15:0] local_ctrl_i,
  input wire dpl_drv_t drv_i,
  input wire logic signed [15:0] act_tq_i,
  input wire logic signed [15:0] act_spd_i,
  input wire logic [15:0] err_num_i,
  input wire logic [15:0] err_loc_i,
  input wire logic rx_valid_i,
  input wire dpl_rxpd_t rx_i,
  output dpl_txpd_t tx_o,
  output dpl_cmd_t cmd_o,
  output logic signed [15:0] spd_ref_o,
  output logic signed [15:0] tq_limit_o,
  output logic signed [15:0] tq_pre_o,
  output logic p_only_o,
  output logic [15:0] rem_err_num_o,
  output logic [15:0] rem_err_loc_o
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] ctlsrc;
    dpl_mode_t mode;
    logic [2:0][31:0] smap;
    logic [2:0][31:0] rmap;
    logic [PCT_W-1:0] pct;
    logic [15:0] thr;
    logic [3:0] filt;
    logic signed [15:0] rem_tq;
    logic signed [15:0] rem_spd;
    logic signed [15:0] filt_spd;
    logic [15:0] rem_enum;
    logic [15:0] rem_eloc;
    logic [31:0] rdata;
    dpl_txpd_t tx;
    dpl_cmd_t cmd;
    logic signed [15:0] spd_ref;
    logic signed [15:0] tq_lim;
    logic signed [15:0] tq_pre;
  } dpl_state_t;

  dpl_state_t st_r;
  dpl_state_t st_nxt;

  // Saturate a 17-bit intermediate into signed 16-bit
  function automatic logic signed [15:0] sat16(
    input logic signed [16:0] v
  );
    if (v > 17'sd32767)
      sat16 = 16'sh7FFF;
    else if (v < -17'sd32768)
      sat16 = 16'sh8000;
    else
      sat16 = v[15:0];
  endfunction

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  // Status word assembly
  function automatic logic [15:0] status_word(input dpl_drv_t d);
    logic [15:0] w;
    w = 16'h0000;
    w[DPL_SW_LOOP_ACT] = d.loop_control_active;
    w[DPL_SW_FAULT] = d.fault;
    w[DPL_SW_TQ_FREE] = d.torque_free;
    w[DPL_SW_FSTOP] = d.fast_stop;
    w[DPL_SW_HOMED] = d.homed;
    w[DPL_SW_STATE_LSB +: 3] = d.drive_state;
    status_word = w;
  endfunction

  logic link_sel;
  logic [15:0] stat_w;
  logic [15:0] cw;
  logic [15:0] prim_mag;
  logic [15:0] sec_mag;
  logic [15:0] sec_use;
  logic [PCT_W+15:0] prod;
  logic signed [16:0] ref_sum;
  logic signed [16:0] filt_step;
  logic signed [15:0] spd_src;

  // Link control selected
  assign link_sel = (st_r.ctlsrc == DPL_CTLSRC_LINK);
  assign stat_w = status_word(drv_i);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    cw = 16'h0000;
    prim_mag = 16'h0000;
    sec_mag = 16'h0000;
    sec_use = 16'h0000;
    prod = '0;
    ref_sum = 17'sh00000;
    filt_step = 17'sh00000;
    spd_src = 16'sh0000;

    if (wr_i)
    begin
      unique case (addr_i)
        DPL_A_CTRL: st_nxt.ctrl = wdata_i[15:0];
        DPL_A_CTLSRC: st_nxt.ctlsrc = wdata_i[3:0];
        DPL_A_MODE:
        begin
          st_nxt.mode = dpl_mode_t'(wdata_i[3:0]);
          unique case (dpl_mode_t'(wdata_i[3:0]))
            DPL_MODE_SPD_MASTER:
            begin
              st_nxt.smap = {DPL_MAP_ACT_SPD, DPL_MAP_ACT_TQ,
                DPL_MAP_TWO};
              st_nxt.rmap = {DPL_MAP_ERR_LOC, DPL_MAP_ERR_NUM,
                DPL_MAP_TWO};
            end
            DPL_MODE_SPD_SLAVE1, DPL_MODE_SPD_SLAVE2:
            begin
              st_nxt.smap = {DPL_MAP_ERR_LOC, DPL_MAP_ERR_NUM,
                DPL_MAP_TWO};
              st_nxt.rmap = {DPL_MAP_REM_SPD, DPL_MAP_REM_TQ,
                DPL_MAP_TWO};
            end
            default:
            begin
              // User mode keeps current maps
              st_nxt.mode = DPL_MODE_USER;
            end
          endcase
        end
        DPL_A_SMAP0, DPL_A_SMAP1, DPL_A_SMAP2:
        begin
          if (wdata_i != st_r.smap[addr_i - DPL_A_SMAP0])
          begin
            st_nxt.smap[addr_i - DPL_A_SMAP0] = wdata_i;
            st_nxt.mode = DPL_MODE_USER;
          end
        end
        DPL_A_RMAP0, DPL_A_RMAP1, DPL_A_RMAP2:
        begin
          if (wdata_i != st_r.rmap[addr_i - DPL_A_RMAP0])
          begin
            st_nxt.rmap[addr_i - DPL_A_RMAP0] = wdata_i;
            st_nxt.mode = DPL_MODE_USER;
          end
        end
        DPL_A_PCT: st_nxt.pct = wdata_i[PCT_W-1:0];
        DPL_A_THR: st_nxt.thr = wdata_i[15:0];
        DPL_A_FILT: st_nxt.filt = wdata_i[3:0];
        default: ;
      endcase
    end

    if (rd_i)
    begin
      unique case (addr_i)
        DPL_A_CTRL: st_nxt.rdata = {16'h0000, st_r.ctrl};
        DPL_A_STAT: st_nxt.rdata = {16'h0000, stat_w};
        DPL_A_CTLSRC: st_nxt.rdata = {28'h0000000, st_r.ctlsrc};
        DPL_A_MODE: st_nxt.rdata = {28'h0000000, st_r.mode};
        DPL_A_SMAP0, DPL_A_SMAP1, DPL_A_SMAP2:
          st_nxt.rdata = st_r.smap[addr_i - DPL_A_SMAP0];
        DPL_A_RMAP0, DPL_A_RMAP1, DPL_A_RMAP2:
          st_nxt.rdata = st_r.rmap[addr_i - DPL_A_RMAP0];
        DPL_A_PCT: st_nxt.rdata = 32'(st_r.pct);
        DPL_A_THR: st_nxt.rdata = {16'h0000, st_r.thr};
        DPL_A_ERR: st_nxt.rdata = {st_r.rem_eloc, st_r.rem_enum};
        DPL_A_FILT: st_nxt.rdata = {28'h0000000, st_r.filt};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Received objects in the mode's preset map order; reception held until valid
    if (rx_valid_i)
    begin
      if (st_r.mode == DPL_MODE_SPD_MASTER)
      begin
        st_nxt.rem_enum = rx_i.rx0;
        st_nxt.rem_eloc = rx_i.rx1;
      end
      else
      begin
        st_nxt.rem_tq = rx_i.rx0;
        st_nxt.rem_spd = rx_i.rx1;
      end
    end

    // Outgoing objects
    if (st_r.mode == DPL_MODE_SPD_MASTER)
    begin
      st_nxt.tx.tx0 = act_tq_i;
      st_nxt.tx.tx1 = act_spd_i;
    end
    else
    begin
      st_nxt.tx.tx0 = err_num_i;
      st_nxt.tx.tx1 = err_loc_i;
    end

    if (st_r.mode == DPL_MODE_SPD_MASTER)
      st_nxt.ctrl = own_ctrl_i;

    cw = link_sel ? st_r.ctrl : local_ctrl_i;
    st_nxt.cmd.loop_control_enable = cw[DPL_CW_LOOP_EN];
    st_nxt.cmd.power_stage_on = cw[DPL_CW_PWR_ON];
    st_nxt.cmd.torque_free_stop = cw[DPL_CW_TQ_FREE];
    st_nxt.cmd.fast_stop = cw[DPL_CW_FSTOP];
    st_nxt.cmd.homing_request = cw[DPL_CW_HOME];
    st_nxt.cmd.error_clear = cw[DPL_CW_ECLR];

    filt_step = (17'(st_r.rem_spd) - 17'(st_r.filt_spd)) >>> st_r.filt;
    st_nxt.filt_spd = sat16(17'(st_r.filt_spd) + filt_step);

    unique case (st_r.mode)
      DPL_MODE_SPD_SLAVE1:
      begin
        prim_mag = mag16(st_r.rem_spd);
        prod = prim_mag * st_r.pct;
        sec_mag = 16'(prod / (PCT_W+16)'(100));
        sec_use = (sec_mag < st_r.thr) ? st_r.thr : sec_mag;
        ref_sum = st_r.rem_tq[15] ?
          17'(st_r.rem_spd) - 17'({1'b0, sec_use}) :
          17'(st_r.rem_spd) + 17'({1'b0, sec_use});
        st_nxt.spd_ref = sat16(ref_sum);
        st_nxt.tq_lim = sat16(17'(mag16(st_r.rem_tq)));
        st_nxt.tq_pre = 16'sh0000;
      end
      DPL_MODE_SPD_SLAVE2:
      begin
        spd_src = (st_r.filt == DPL_RST_FILT) ? st_r.rem_spd :
          st_r.filt_spd;
        st_nxt.spd_ref = spd_src;
        st_nxt.tq_lim = 16'sh7FFF;
        st_nxt.tq_pre = st_r.rem_tq;
      end
      default:
      begin
        st_nxt.spd_ref = 16'sh0000;
        st_nxt.tq_lim = 16'sh7FFF;
        st_nxt.tq_pre = 16'sh0000;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '0;
      st_r.mode <= DPL_MODE_USER;
      st_r.pct <= DPL_RST_PCT;
      st_r.thr <= DPL_RST_THR;
      st_r.filt <= DPL_RST_FILT;
      st_r.tq_lim <= 16'sh7FFF;
    end
    else if (ce_i)
      st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;
  assign tx_o = st_r.tx;
  assign cmd_o = st_r.cmd;
  assign spd_ref_o = st_r.spd_ref;
  assign tq_limit_o = st_r.tq_lim;
  assign tq_pre_o = st_r.tq_pre;
  assign p_only_o = (st_r.mode == DPL_MODE_SPD_SLAVE2);
  assign rem_err_num_o = st_r.rem_enum;
  assign rem_err_loc_o = st_r.rem_eloc;

  // fast stop command follows bit 8 of the selected control word
  a_cmd_source: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i ##1 1 |-> cmd_o.fast_stop == $past(link_sel ? st_r.ctrl[8] :
    local_ctrl_i[8])) else $error("command source wrong");

  a_stat_resv: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    (stat_w & 16'h1C1F) == 16'h0000)
    else $error("reserved status set");

  a_state_bits: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    stat_w[15:13] == drv_i.drive_state)
    else $error("state bits wrong");

  a_map_user: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == DPL_A_SMAP1 && wdata_i != st_r.smap[1]
    |=> st_r.mode == DPL_MODE_USER) else $error("map kept mode");

  a_master_tx: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && st_r.mode == DPL_MODE_SPD_MASTER |=> tx_o.tx0 ==
    $past(act_tq_i)) else $error("master tx wrong");

  a_slave1_lim: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && st_r.mode == DPL_MODE_SPD_SLAVE1 && !st_r.rem_tq[15] &&
    st_r.rem_tq != 16'sh0000 |=> tq_limit_o == $past(st_r.rem_tq))
    else $error("limit not tracked");

  a_slave1_sign: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && st_r.mode == DPL_MODE_SPD_SLAVE1 && st_r.rem_tq[15] &&
    st_r.thr != 16'h0000 && st_r.rem_spd > -16'sd30000
    |=> spd_ref_o < $past(st_r.rem_spd)) else $error("sign wrong");

  a_slave2_pre: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i && st_r.mode == DPL_MODE_SPD_SLAVE2 |=> tq_pre_o ==
    $past(st_r.rem_tq)) else $error("pre-control wrong");

endmodule

//--- verilog/dpl_pkg.sv
package dpl_pkg;

  // Register map (word addresses of the plain register port)
  localparam logic [3:0] DPL_A_CTRL = 4'h0;
  localparam logic [3:0] DPL_A_STAT = 4'h1;
  localparam logic [3:0] DPL_A_CTLSRC = 4'h2;
  localparam logic [3:0] DPL_A_MODE = 4'h3;
  localparam logic [3:0] DPL_A_SMAP0 = 4'h4;
  localparam logic [3:0] DPL_A_SMAP1 = 4'h5;
  localparam logic [3:0] DPL_A_SMAP2 = 4'h6;
  localparam logic [3:0] DPL_A_RMAP0 = 4'h7;
  localparam logic [3:0] DPL_A_RMAP1 = 4'h8;
  localparam logic [3:0] DPL_A_RMAP2 = 4'h9;
  localparam logic [3:0] DPL_A_PCT = 4'hA;
  localparam logic [3:0] DPL_A_THR = 4'hB;
  localparam logic [3:0] DPL_A_ERR = 4'hC;
  localparam logic [3:0] DPL_A_FILT = 4'hD;

  // Control location value selecting the link
  localparam logic [3:0] DPL_CTLSRC_LINK = 4'h8;

  // Control word bit positions
  localparam int DPL_CW_LOOP_EN = 5;
  localparam int DPL_CW_PWR_ON = 6;
  localparam int DPL_CW_TQ_FREE = 7;
  localparam int DPL_CW_FSTOP = 8;
  localparam int DPL_CW_HOME = 9;
  localparam int DPL_CW_ECLR = 10;
  localparam logic [15:0] DPL_CW_MASK = 16'h07E0;

  // Status word bit positions
  localparam int DPL_SW_LOOP_ACT = 5;
  localparam int DPL_SW_FAULT = 6;
  localparam int DPL_SW_TQ_FREE = 7;
  localparam int DPL_SW_FSTOP = 8;
  localparam int DPL_SW_HOMED = 9;
  localparam int DPL_SW_STATE_LSB = 13;

  // Operation modes
  typedef enum logic [3:0] {
    DPL_MODE_USER = 4'h0,
    DPL_MODE_SPD_MASTER = 4'h1,
    DPL_MODE_SPD_SLAVE1 = 4'h2,
    DPL_MODE_SPD_SLAVE2 = 4'h3
  } dpl_mode_t;

  // Preset process-data maps
  localparam logic [31:0] DPL_MAP_TWO = 32'h0000_0002;
  localparam logic [31:0] DPL_MAP_ACT_TQ = 32'h0A25_0010;
  localparam logic [31:0] DPL_MAP_ACT_SPD = 32'h0A27_0010;
  localparam logic [31:0] DPL_MAP_ERR_NUM = 32'h0A5A_0010;
  localparam logic [31:0] DPL_MAP_ERR_LOC = 32'h0A5A_0110;
  localparam logic [31:0] DPL_MAP_REM_TQ = 32'h0A2C_0010;
  localparam logic [31:0] DPL_MAP_REM_SPD = 32'h0A2E_0010;

  // Reset values
  localparam logic [15:0] DPL_RST_WORD = 16'h0000;
  localparam logic [6:0] DPL_RST_PCT = 7'h00;
  localparam logic [15:0] DPL_RST_THR = 16'h0000;
  localparam logic [3:0] DPL_RST_FILT = 4'h0;

  // Link words carried together
  typedef struct packed {
    logic [15:0] tx0;
    logic [15:0] tx1;
  } dpl_txpd_t;

  typedef struct packed {
    logic [15:0] rx0;
    logic [15:0] rx1;
  } dpl_rxpd_t;

  // Commands decoded from the selected control word (link or local)
  typedef struct packed {
    logic loop_control_enable;
    logic power_stage_on;
    logic torque_free_stop;
    logic fast_stop;
    logic homing_request;
    logic error_clear;
  } dpl_cmd_t;

  // Local drive state reported in the status word
  typedef struct packed {
    logic loop_control_active;
    logic fault;
    logic torque_free;
    logic fast_stop;
    logic homed;
    logic [2:0] drive_state;
  } dpl_drv_t;

endpackage

//--- sim/dpl_far_drive.sv
`timescale 1ns/1ns
module dpl_far_drive
  import dpl_pkg::*;
(
  input wire logic mclk_i,
  output logic rx_valid_o,
  output dpl_rxpd_t rx_o
);
  logic busy;
  initial
  begin
    busy = 1'b0;
    rx_valid_o = 1'b0;
    rx_o = 32'h5A5A_A5A5;
  end
  // Idle words toggle, so stale data never looks valid
  always @(posedge mclk_i)
  begin
    if (!busy)
      rx_o <= ~rx_o;
  end
  task automatic send(input logic [15:0] w0, input logic [15:0] w1,
                      input int gap);
    busy = 1'b1;
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_o <= {w0, w1};
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_o <= ~{w0, w1};
    #1 busy = 1'b0;
  endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ns
module tb
  import dpl_pkg::*;
;
  logic mclk_i, rst_b_i, ce_i, wr_i, rd_i, rx_valid_i, p_only_o;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [15:0] own_ctrl_i, local_ctrl_i, err_num_i, err_loc_i;
  logic [15:0] rem_err_num_o, rem_err_loc_o;
  logic signed [15:0] act_tq_i, act_spd_i, spd_ref_o, tq_limit_o, tq_pre_o;
  dpl_drv_t drv_i;
  dpl_rxpd_t rx_i;
  dpl_txpd_t tx_o;
  dpl_cmd_t cmd_o;
  int mismatches, checks;

  dpl_core i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .own_ctrl_i(own_ctrl_i),
    .local_ctrl_i(local_ctrl_i), .drv_i(drv_i), .act_tq_i(act_tq_i),
    .act_spd_i(act_spd_i), .err_num_i(err_num_i), .err_loc_i(err_loc_i),
    .rx_valid_i(rx_valid_i), .rx_i(rx_i), .tx_o(tx_o), .cmd_o(cmd_o),
    .spd_ref_o(spd_ref_o), .tq_limit_o(tq_limit_o), .tq_pre_o(tq_pre_o),
    .p_only_o(p_only_o), .rem_err_num_o(rem_err_num_o),
    .rem_err_loc_o(rem_err_loc_o));
  dpl_far_drive i_far (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i),
    .rx_o(rx_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic conclude();
    $display("Summary: %0d mismatches in %0d checks", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string n);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    tick(1);
    chk("tq_limit", 32'h0000_7FFF, 32'(tq_limit_o));
    rdchk(DPL_A_MODE, 32'h0, "mode");
    rdchk(DPL_A_CTLSRC, 32'h0, "ctlsrc");
    rdchk(DPL_A_SMAP1, 32'h0, "smap1");
    rdchk(4'hE, 32'h0, "unmapped");
  endtask

  task automatic t_status();
    logic [7:0] d;
    for (int k = 0; k < 8; k++)
    begin
      d = 8'h01 << k;
      @(posedge mclk_i);
      drv_i <= dpl_drv_t'(d);
      rdchk(DPL_A_STAT, {16'h0, d[2:0], 3'h0, d[3], d[4], d[5], d[6], d[7],
        5'h00}, "status");
    end
  endtask

  function automatic logic [5:0] cmdof(input logic [15:0] w);
    return {w[5], w[6], w[7], w[8], w[9], w[10]};
  endfunction

  task automatic t_ctrl();
    logic [3:0] srcs [5];
    srcs = '{4'h0, 4'h7, 4'h9, 4'hF, 4'h8};
    @(posedge mclk_i);
    local_ctrl_i <= 16'h02C0;
    wr(DPL_A_CTRL, 32'h0000_0520);
    foreach (srcs[i])
    begin
      wr(DPL_A_CTLSRC, {28'h0, srcs[i]});
      tick(3);
      chk("cmd", 32'(cmdof(srcs[i] == 4'h8 ? 16'h0520 : 16'h02C0)),
        32'(cmd_o));
    end
    wr(DPL_A_CTRL, 32'h0000_F81F);
    tick(3);
    chk("cmd", 32'h0, 32'(cmd_o));
    wr(DPL_A_CTRL, 32'h0000_07E0);
    tick(3);
    chk("cmd", 32'h3F, 32'(cmd_o));
  endtask

  task automatic t_modes();
    logic [31:0] ex [6];
    for (int m = 1; m < 4; m++)
    begin
      wr(DPL_A_MODE, 32'(m));
      rdchk(DPL_A_MODE, 32'(m), "mode");
      if (m == 1)
        ex = '{DPL_MAP_TWO, DPL_MAP_ACT_TQ, DPL_MAP_ACT_SPD,
               DPL_MAP_TWO, DPL_MAP_ERR_NUM, DPL_MAP_ERR_LOC};
      else
        ex = '{DPL_MAP_TWO, DPL_MAP_ERR_NUM, DPL_MAP_ERR_LOC,
               DPL_MAP_TWO, DPL_MAP_REM_TQ, DPL_MAP_REM_SPD};
      for (int a = 0; a < 6; a++)
        rdchk(4'(DPL_A_SMAP0 + a), ex[a], "map");
    end
    wr(DPL_A_SMAP0, DPL_MAP_TWO);
    rdchk(DPL_A_MODE, 32'h3, "mode");
    wr(DPL_A_RMAP2, 32'h0A2D_0010);
    rdchk(DPL_A_MODE, 32'h0, "mode");
    rdchk(DPL_A_RMAP2, 32'h0A2D_0010, "rmap2");
    wr(DPL_A_MODE, 32'h2);
    wr(DPL_A_SMAP1, 32'h0A25_0010);
    rdchk(DPL_A_MODE, 32'h0, "mode");
    wr(DPL_A_MODE, 32'h2);
    wr(DPL_A_MODE, 32'h5);
    rdchk(DPL_A_MODE, 32'h0, "mode");
    rdchk(DPL_A_SMAP1, DPL_MAP_ERR_NUM, "smap1");
  endtask

  task automatic t_master();
    wr(DPL_A_MODE, 32'h1);
    @(posedge mclk_i);
    act_tq_i <= 16'hFED4;
    act_spd_i <= 16'h05DC;
    own_ctrl_i <= 16'h0A60;
    tick(3);
    chk("tx0", 32'h0000_FED4, 32'(tx_o.tx0));
    chk("tx1", 32'h0000_05DC, 32'(tx_o.tx1));
    rdchk(DPL_A_CTRL, 32'h0000_0A60, "ctrl");
    i_far.send(16'h002E, 16'h0107, 4);
    tick(3);
    chk("err_num", 32'h002E, 32'(rem_err_num_o));
    chk("err_loc", 32'h0107, 32'(rem_err_loc_o));
    @(posedge mclk_i);
    ce_i <= 1'b0;
    i_far.send(16'h1111, 16'h2222, 0);
    tick(3);
    chk("frozen", 32'h002E, 32'(rem_err_num_o));
    @(posedge mclk_i);
    ce_i <= 1'b1;
  endtask

  function automatic int exref(input int tq, input int spd);
    int s;
    s = (spd < 0 ? -spd : spd) * 10 / 100;
    if (s < 50)
      s = 50;
    if (tq < 0)
      s = -s;
    s = s + spd;
    return s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
  endfunction

  task automatic t_slave1();
    int tq [5];
    int sp [5];
    tq = '{400, -400, -400, 200, 100};
    sp = '{1000, 1000, 100, -1000, 32000};
    wr(DPL_A_MODE, 32'h2);
    wr(DPL_A_PCT, 32'd10);
    wr(DPL_A_THR, 32'd50);
    foreach (tq[i])
    begin
      i_far.send(16'(tq[i]), 16'(sp[i]), i);
      tick(3);
      chk("spd_ref", 32'(exref(tq[i], sp[i])),
        32'(spd_ref_o));
      chk("tq_limit", 32'(tq[i] < 0 ? -tq[i] : tq[i]),
        32'(tq_limit_o));
      chk("p_only", 32'h0, 32'(p_only_o));
    end
  endtask

  task automatic t_slave2();
    wr(DPL_A_MODE, 32'h3);
    wr(DPL_A_FILT, 32'h0);
    i_far.send(16'h0309, 16'hF830, 1);
    tick(3);
    chk("spd_ref", 32'hFFFF_F830, 32'(spd_ref_o));
    chk("tq_pre", 32'h0000_0309, 32'(tq_pre_o));
    chk("p_only", 32'h1, 32'(p_only_o));
    chk("tx0", 32'h0000_0033, 32'(tx_o.tx0));
    chk("tx1", 32'h0000_0044, 32'(tx_o.tx1));
    // Lag shift 2: first step moves a quarter of the way
    wr(DPL_A_FILT, 32'h2);
    i_far.send(16'h0309, 16'h0400, 0);
    tick(2);
    chk("lag", 32'hFFFF_FB24, 32'(spd_ref_o));
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    own_ctrl_i = 16'h0;
    local_ctrl_i = 16'h0;
    drv_i = '0;
    act_tq_i = 16'h0;
    act_spd_i = 16'h0;
    err_num_i = 16'h0033;
    err_loc_i = 16'h0044;
    mismatches = 0;
    checks = 0;
    do_reset();
    t_status();
    t_ctrl();
    t_modes();
    t_master();
    t_slave1();
    t_slave2();
    do_reset();
    conclude();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    $display("[FAIL] run expected end seen hang");
    conclude();
  end
endmodule
